// >>> include/scp_defines.svh
// Register offsets, field positions, reset values and cycle counts of the clock prescaler.
`ifndef SCP_DEFINES_SVH
`define SCP_DEFINES_SVH
`define SCP_ADDR_W        2
`define SCP_ADDR_TRIM     2'h0
`define SCP_ADDR_CTRL     2'h1
`define SCP_UNLOCK_BIT    7
`define SCP_SEL_MSB       3
`define SCP_CTRL_UNLOCK   8'h80
`define SCP_SEL_RST_DIV1  4'h0
`define SCP_SEL_RST_DIV8  4'h3
`define SCP_SEL_MAX       4'h8
`define SCP_UNLOCK_CYCLES 4
`endif

// >>> include/scp_pkg.sv
// Types shared by the clock prescaler modules.
package scp_pkg;
   typedef enum logic [0:0] {
      SCP_LOCKED = 1'b0,
      SCP_OPEN   = 1'b1
   } scp_lock_t;
   typedef logic [3:0] scp_sel_t;
endpackage

// >>> include/scp_div_if.sv
// Link between the prescaler register logic and its divider.
`timescale 1ns/100ps
`default_nettype none
interface scp_div_if;
   scp_pkg::scp_sel_t sel;
   scp_pkg::scp_sel_t cur;
   logic              tick;
   logic              level;
   modport drv (input sel, output cur, output tick, output level);
   modport use_side (output sel, input cur, input tick, input level);
endinterface
`default_nettype wire

// >>> hw/scp_unlock_window.sv
// Timed window that opens the division field for a short while after a clean unlock write.
`timescale 1ns/100ps
`default_nettype none
`include "scp_defines.svh"
module scp_unlock_window #(
   parameter int COUNT = `SCP_UNLOCK_CYCLES
) (
   // Clock and reset
   input  wire logic i_clock,
   input  wire logic i_rst,
   // Control
   input  wire logic i_start,
   input  wire logic i_cancel,
   // Status
   output logic      o_open
);
   localparam int CW = $clog2(COUNT + 1);
   localparam logic [CW-1:0] LAST = CW'(COUNT - 1);

   scp_pkg::scp_lock_t state_q;
   scp_pkg::scp_lock_t state_d;
   logic [CW-1:0]      cnt_q;
   logic [CW-1:0]      cnt_d;

   // A second unlock while open is ignored, so the window cannot be stretched.
   always_comb begin
      state_d = state_q;
      cnt_d   = cnt_q;
      case (state_q)
         scp_pkg::SCP_LOCKED: begin
            cnt_d = '0;
            if (i_start && !i_cancel) begin
               state_d = scp_pkg::SCP_OPEN;
            end
         end
         scp_pkg::SCP_OPEN: begin
            cnt_d = cnt_q + CW'(1);
            if (i_cancel || cnt_q == LAST) begin
               state_d = scp_pkg::SCP_LOCKED;
            end
         end
         default: begin
            state_d = scp_pkg::SCP_LOCKED;
         end
      endcase
   end

   always_ff @(posedge i_clock or posedge i_rst) begin
      if (i_rst) begin
         state_q <= scp_pkg::SCP_LOCKED;
         cnt_q   <= '0;
      end else begin
         state_q <= state_d;
         cnt_q   <= cnt_d;
      end
   end

   assign o_open = (state_q == scp_pkg::SCP_OPEN);

   default clocking @(posedge i_clock); endclocking
   default disable iff (i_rst);

   AST_WINDOW_COUNT_BOUND: assert property (o_open |-> cnt_q <= LAST)
      else $error("Unlock window counted past its length.");
endmodule
`default_nettype wire

// >>> hw/scp_divider.sv
// Power-of-two divider that switches factor only at the end of a whole divided period.
`timescale 1ns/100ps
`default_nettype none
`include "scp_defines.svh"
module scp_divider (
   // Clock and reset
   input  wire logic i_clock,
   input  wire logic i_rst,
   // Divider link
   scp_div_if.drv    div
);
   logic [7:0]        cnt_q;
   scp_pkg::scp_sel_t cur_q;
   logic              tick_q;
   logic              level_q;

   function automatic logic [7:0] scp_mask(input scp_pkg::scp_sel_t s);
      logic [8:0] one_hot;
      one_hot = 9'h001 << s;
      return one_hot[7:0] - 8'h01;
   endfunction

   // Reserved codes act as the largest factor rather than something faster.
   wire scp_pkg::scp_sel_t sel_clamped = (div.sel > `SCP_SEL_MAX) ? `SCP_SEL_MAX : div.sel;
   wire [7:0]              cur_mask    = (cur_q == `SCP_SEL_MAX) ? 8'hFF : scp_mask(cur_q);
   wire                    wrap        = (cnt_q == cur_mask);

   // The factor changes only at a period boundary, so no pulse is cut short.
   always_ff @(posedge i_clock or posedge i_rst) begin
      if (i_rst) begin
         cnt_q   <= 8'h00;
         cur_q   <= `SCP_SEL_RST_DIV1;
         tick_q  <= 1'b0;
         level_q <= 1'b0;
      end else if (wrap) begin
         cnt_q   <= 8'h00;
         cur_q   <= sel_clamped;
         tick_q  <= 1'b1;
         level_q <= ~level_q;
      end else begin
         cnt_q   <= cnt_q + 8'h01;
         tick_q  <= 1'b0;
      end
   end

   assign div.cur   = cur_q;
   assign div.tick  = tick_q;
   assign div.level = level_q;

   default clocking @(posedge i_clock); endclocking
   default disable iff (i_rst);

   AST_COUNT_IN_PERIOD: assert property (cnt_q <= cur_mask)
      else $error("Divider count left the current period.");
   AST_SWITCH_ONLY_AT_WRAP: assert property (!wrap |=> $stable(cur_q))
      else $error("Division factor changed inside a period.");
   AST_TICK_AFTER_WRAP: assert property (wrap |=> tick_q && level_q != $past(level_q))
      else $error("Divided clock missed its edge at a period end.");
endmodule
`default_nettype wire

// >>> hw/scp_prescaler.sv
// Top of the system clock prescaler: registers, unlock sequencing, clock fan-out and clock-out pin.
`timescale 1ns/100ps
`default_nettype none
`include "scp_defines.svh"
// What this block does
// - Clock-out fuse drives system clock onto pin.
// - Pin shows clock during reset, overriding port.
// - Pin carries the divided clock, not source.
// - One factor drives core, memory, I/O, converter.
// - Factor change makes no glitch or runt.
// - No intermediate frequency above old and new.
// - New rate active within old plus two new.
// - Divider count state is never software visible.
// - Division field changes only while unlocked.
// - Unlock bit sets only with others zero.
// - Unlock clears after four cycles or field write.
// - Unlock rewrite neither extends nor clears window.
// - Reset loads divide one, or eight by fuse.
// - Any factor writable regardless of the fuse.
// - Field codes two to power, up to 256.
// - Chip reset loads factory trim value.
// - Software trim writes retune the oscillator.
// - Top trim bit picks low or high range.
// - Lower seven trim bits tune within range.
module scp_prescaler #(
   parameter int UNLOCK_CYCLES = `SCP_UNLOCK_CYCLES
) (
   // Clock and resets
   input  wire logic                   i_clock,
   input  wire logic                   i_rst,
   input  wire logic                   i_chip_reset,
   // Fuses and factory data
   input  wire logic                   i_clock_out_fuse,
   input  wire logic                   i_start_divide_by_eight_fuse,
   input  wire logic [7:0]             i_factory_trim,
   // Register port
   input  wire logic [`SCP_ADDR_W-1:0] i_addr,
   input  wire logic [7:0]             i_wdata,
   input  wire logic                   i_wr,
   input  wire logic                   i_rd,
   output logic [7:0]                  o_rdata,
   // Ordinary port function of the shared pin
   input  wire logic                   i_port_out,
   input  wire logic                   i_port_oe,
   // Clock enables of the four domains
   output logic                        o_core_clock_en,
   output logic                        o_program_memory_clock_en,
   output logic                        o_io_clock_en,
   output logic                        o_converter_clock_en,
   // Clock-out pin
   output logic                        o_clock_out_pin,
   output logic                        o_clock_out_pin_oe,
   // Oscillator trim word
   output logic [7:0]                  o_rc_osc_trim
);
   logic [7:0]        trim_q;
   scp_pkg::scp_sel_t sel_q;
   logic              init_q;
   logic              dom_en_q;
   logic              pin_q;
   logic              pin_oe_q;
   logic [7:0]        rdata_q;
   logic              unlock_open;

   scp_div_if div ();

   // Defaults are loaded in the cycle after the asynchronous reset and while chip reset is held.
   wire load_defaults = init_q | i_chip_reset;

   wire wr_trim = i_wr & (i_addr == `SCP_ADDR_TRIM) & ~load_defaults;
   wire wr_ctrl = i_wr & (i_addr == `SCP_ADDR_CTRL) & ~load_defaults;

   wire clean_unlock = wr_ctrl & (i_wdata == `SCP_CTRL_UNLOCK);
   wire sel_write    = wr_ctrl & ~i_wdata[`SCP_UNLOCK_BIT] & unlock_open;

   wire scp_pkg::scp_sel_t reset_sel =
      i_start_divide_by_eight_fuse ? `SCP_SEL_RST_DIV8 : `SCP_SEL_RST_DIV1;

   // The divider count is kept out of the read path on purpose.
   wire [7:0] ctrl_view = {unlock_open, 3'h0, sel_q};

   wire hit_trim = (i_addr == `SCP_ADDR_TRIM);
   wire hit_ctrl = (i_addr == `SCP_ADDR_CTRL);

   wire [7:0] rd_mux  = hit_trim ? trim_q : (hit_ctrl ? ctrl_view : 8'h00);
   wire [7:0] rd_next = i_rd ? rd_mux : 8'h00;

   // The fuse overrides the port function, also while chip reset is held.
   wire pin_next    = i_clock_out_fuse ? div.level : i_port_out;
   wire pin_oe_next = i_clock_out_fuse | i_port_oe;

   assign div.sel = sel_q;

   scp_unlock_window #(
      .COUNT (UNLOCK_CYCLES)
   ) u_window (
      .i_clock  (i_clock),
      .i_rst    (i_rst),
      .i_start  (clean_unlock),
      .i_cancel (sel_write | load_defaults),
      .o_open   (unlock_open)
   );

   scp_divider u_divider (
      .i_clock (i_clock),
      .i_rst   (i_rst),
      .div     (div)
   );

   always_ff @(posedge i_clock or posedge i_rst) begin
      if (i_rst) begin
         init_q <= 1'b1;
      end else begin
         init_q <= 1'b0;
      end
   end

   // Trim word: zero during asynchronous reset, factory value after it and on chip reset, software value otherwise.
   always_ff @(posedge i_clock or posedge i_rst) begin
      if (i_rst) begin
         trim_q <= 8'h00;
      end else if (load_defaults) begin
         trim_q <= i_factory_trim;
      end else if (wr_trim) begin
         trim_q <= i_wdata;
      end
   end

   // Division field: any code is accepted once unlocked, whatever the fuse says.
   always_ff @(posedge i_clock or posedge i_rst) begin
      if (i_rst) begin
         sel_q <= `SCP_SEL_RST_DIV1;
      end else if (load_defaults) begin
         sel_q <= reset_sel;
      end else if (sel_write) begin
         sel_q <= i_wdata[`SCP_SEL_MSB:0];
      end
   end

   // A single enable flop feeds every domain so they can never drift apart.
   always_ff @(posedge i_clock or posedge i_rst) begin
      if (i_rst) begin
         dom_en_q <= 1'b0;
      end else begin
         dom_en_q <= div.tick;
      end
   end

   always_ff @(posedge i_clock or posedge i_rst) begin
      if (i_rst) begin
         pin_q    <= 1'b0;
         pin_oe_q <= 1'b0;
      end else begin
         pin_q    <= pin_next;
         pin_oe_q <= pin_oe_next;
      end
   end

   always_ff @(posedge i_clock or posedge i_rst) begin
      if (i_rst) begin
         rdata_q <= 8'h00;
      end else begin
         rdata_q <= rd_next;
      end
   end

   assign o_rdata                   = rdata_q;
   assign o_core_clock_en           = dom_en_q;
   assign o_program_memory_clock_en = dom_en_q;
   assign o_io_clock_en             = dom_en_q;
   assign o_converter_clock_en      = dom_en_q;
   assign o_clock_out_pin           = pin_q;
   assign o_clock_out_pin_oe        = pin_oe_q;
   // Bit 7 picks the range and bits 6 to 0 tune within it; the oscillator reads the word whole.
   assign o_rc_osc_trim             = trim_q;

   default clocking @(posedge i_clock); endclocking
   default disable iff (i_rst);

   sequence s_armed;
      clean_unlock && !unlock_open;
   endsequence

   sequence s_quiet_3;
      (!sel_write && !i_chip_reset)[*3];
   endsequence

   sequence s_quiet_4;
      (!sel_write && !i_chip_reset)[*4];
   endsequence

   AST_PIN_FOLLOWS_CLOCK: assert property (
      i_clock_out_fuse |=> o_clock_out_pin_oe && o_clock_out_pin == $past(div.level))
      else $error("Clock-out pin does not follow the divided clock.");

   AST_PIN_IN_RESET: assert property (
      i_clock_out_fuse && i_chip_reset && i_port_oe == 1'b0
      |=> o_clock_out_pin_oe && o_clock_out_pin == $past(div.level))
      else $error("Clock-out pin lost the clock during chip reset.");

   AST_PIN_DIVIDED: assert property (
      i_clock_out_fuse && div.tick |=> o_clock_out_pin == $past(div.level))
      else $error("Clock-out pin does not carry the divided clock.");

   AST_DOMAINS_TOGETHER: assert property (
      div.tick |=> o_core_clock_en && o_io_clock_en
                   && o_program_memory_clock_en && o_converter_clock_en)
      else $error("A clock domain missed the common enable.");

   AST_SEL_LOCKED: assert property (
      i_wr && !unlock_open && !load_defaults |=> $stable(sel_q))
      else $error("Division field changed while locked.");

   AST_SEL_TAKEN: assert property (
      sel_write |=> sel_q == $past(i_wdata[`SCP_SEL_MSB:0]) && !unlock_open)
      else $error("Unlocked division write not taken.");

   AST_UNLOCK_DIRTY: assert property (
      wr_ctrl && i_wdata[`SCP_UNLOCK_BIT] && i_wdata[6:0] != 7'h00 && !unlock_open
      |=> !unlock_open)
      else $error("Unlock set by a write with other bits high.");

   AST_UNLOCK_SETS: assert property (
      s_armed |=> unlock_open)
      else $error("Clean unlock write did not open the window.");

   AST_WINDOW_HOLDS: assert property (
      s_armed ##1 s_quiet_3 |-> unlock_open)
      else $error("Unlock window closed early.");

   AST_WINDOW_CLOSES: assert property (
      s_armed ##1 s_quiet_4 |=> !unlock_open)
      else $error("Unlock window stayed open past four cycles.");

   AST_RESET_SEL: assert property (
      i_chip_reset |=> sel_q == $past(reset_sel))
      else $error("Division field not reset from the fuse.");

   AST_TRIM_RESET: assert property (
      i_chip_reset |=> o_rc_osc_trim == $past(i_factory_trim))
      else $error("Trim not loaded with the factory value.");

   AST_TRIM_WRITE: assert property (
      wr_trim |=> o_rc_osc_trim == $past(i_wdata))
      else $error("Trim write not taken.");

   AST_READ_HIDES_COUNT: assert property (
      i_rd && hit_ctrl |=> o_rdata[6:4] == 3'h0 && o_rdata[3:0] == $past(sel_q))
      else $error("Control read shows more than the field.");

   AST_READ_ONE_CYCLE: assert property (
      !i_rd |=> o_rdata == 8'h00)
      else $error("Read data present without a read.");

   AST_FACTOR_REACHED: assert property (
      div.tick && div.sel <= `SCP_SEL_MAX |-> ##[0:1] div.cur == $past(div.sel))
      else $error("Divider did not adopt the field at a period end.");
endmodule
`default_nettype wire

// >>> dv/scp_domain_model.sv
// Partner model of the clocked domains and the board circuit fed by the prescaler.
`timescale 1ns/100ps
`default_nettype none
module scp_domain_model (
   // Clock and reset
   input  wire logic       i_clock,
   input  wire logic       i_rst,
   // Domain enables and clock-out pin
   input  wire logic [3:0] i_en,
   input  wire logic       i_pin,
   // Measured figures
   output logic [8:0]      o_gap,
   output logic [8:0]      o_pin_gap,
   output int              o_pulses,
   output int              o_skew
);
   logic [8:0] cnt_q;
   logic [8:0] pcnt_q;
   logic       pin_q;
   wire        pin_edge = i_pin != pin_q;
   // A domain that ticks apart from the others would desynchronise the peripherals, so splits are counted.
   always_ff @(posedge i_clock or posedge i_rst) begin
      if (i_rst) begin
         cnt_q     <= 9'h001;
         pcnt_q    <= 9'h001;
         pin_q     <= 1'b0;
         o_gap     <= 9'h000;
         o_pin_gap <= 9'h000;
         o_pulses  <= 0;
         o_skew    <= 0;
      end else begin
         cnt_q  <= i_en[0] ? 9'h001 : cnt_q + 9'h001;
         pcnt_q <= pin_edge ? 9'h001 : pcnt_q + 9'h001;
         pin_q  <= i_pin;
         if (i_en[0]) begin
            o_gap    <= cnt_q;
            o_pulses <= o_pulses + 1;
         end
         if (pin_edge) begin
            o_pin_gap <= pcnt_q;
         end
         if (i_en != {4{i_en[0]}}) begin
            o_skew <= o_skew + 1;
         end
      end
   end
endmodule
`default_nettype wire

// >>> dv/scp_prescaler_tb.sv
// Self-checking bench of the system clock prescaler.
`timescale 1ns/100ps
`default_nettype none
`include "scp_defines.svh"
module scp_prescaler_tb;
   logic                   i_clock, i_rst, i_chip_reset, i_clock_out_fuse, i_start_divide_by_eight_fuse;
   logic                   i_wr, i_rd, i_port_out, i_port_oe, pv;
   logic [`SCP_ADDR_W-1:0] i_addr;
   logic [7:0]             i_wdata, i_factory_trim, o_rdata, o_rc_osc_trim, rd_q, tv;
   logic [3:0]             en;
   logic                   o_clock_out_pin, o_clock_out_pin_oe;
   logic [8:0]             m_gap, m_pin_gap, mn;
   logic [3:0]             nw, old;
   int                     m_pulses, m_skew, miscompares, n_checks, el, tg, off;
   scp_prescaler scp_prescaler_inst (.i_clock(i_clock), .i_rst(i_rst), .i_chip_reset(i_chip_reset),
      .i_clock_out_fuse(i_clock_out_fuse), .i_start_divide_by_eight_fuse(i_start_divide_by_eight_fuse),
      .i_factory_trim(i_factory_trim), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd),
      .o_rdata(o_rdata), .i_port_out(i_port_out), .i_port_oe(i_port_oe), .o_core_clock_en(en[0]),
      .o_program_memory_clock_en(en[1]), .o_io_clock_en(en[2]), .o_converter_clock_en(en[3]),
      .o_clock_out_pin(o_clock_out_pin), .o_clock_out_pin_oe(o_clock_out_pin_oe), .o_rc_osc_trim(o_rc_osc_trim));
   scp_domain_model scp_domain_model_inst (.i_clock(i_clock), .i_rst(i_rst), .i_en(en), .i_pin(o_clock_out_pin),
      .o_gap(m_gap), .o_pin_gap(m_pin_gap), .o_pulses(m_pulses), .o_skew(m_skew));
   initial begin
      i_clock = 1'b0;
      forever #2 i_clock = ~i_clock;
   end
   task automatic stop_test();
      $display("checks %0d miscompares %0d", n_checks, miscompares);
      if (miscompares == 0 && n_checks > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
      n_checks++;
      if (g !== e) begin
         $display("CHECK FAILED %s expected %h seen %h", n, e, g);
         miscompares++;
      end
   endtask
   // One bus cycle; the read data of the previous cycle is caught before this edge's updates land.
   task automatic cyc(input logic w, input logic r, input logic [1:0] a, input logic [7:0] d);
      i_wr    <= w;
      i_rd    <= r;
      i_addr  <= a;
      i_wdata <= d;
      @(posedge i_clock);
      rd_q = o_rdata;
   endtask
   task automatic rd(input logic [1:0] a, input logic [7:0] e);
      cyc(1'b0, 1'b1, a, 8'h00);
      cyc(1'b0, 1'b0, a, 8'h00);
      chk("rdata", {8'h00, e}, {8'h00, rd_q});
   endtask
   task automatic idle(input int n);
      repeat (n) cyc(1'b0, 1'b0, 2'h0, 8'h00);
   endtask
   task automatic pulse();
      int k;
      k = m_pulses + 1;
      while (m_pulses < k && el < 2000) begin
         idle(1);
         el++;
      end
      if (m_gap < mn) mn = m_gap;
   endtask
   initial begin
      repeat (100000) @(posedge i_clock);
      miscompares++;
      stop_test();
   end
   initial begin
      off = int'($urandom(29686) % 32'd9);
      i_rst = 1'b1;
      i_chip_reset = 1'b0;
      i_clock_out_fuse = 1'b1;
      i_start_divide_by_eight_fuse = 1'b1;
      i_factory_trim = $urandom;
      {i_wr, i_rd, i_port_out, i_port_oe, i_addr, i_wdata} = '0;
      repeat (16) @(posedge i_clock);
      i_rst <= 1'b0;
      idle(2);
      rd(`SCP_ADDR_TRIM, i_factory_trim);
      rd(`SCP_ADDR_CTRL, 8'h03);
      repeat (3) pulse();
      chk("gap", 16'h8, m_gap);
      chk("pin gap", 16'h8, m_pin_gap);
      chk("pin oe", 16'h1, o_clock_out_pin_oe);
      // No memory writes run in the bench, so any trim word is a legal choice here.
      for (int i = 0; i < 5; i++) begin
         tv = (i == 0) ? 8'h7F : (i == 1) ? 8'h80 : 8'($urandom);
         cyc(1'b1, 1'b0, `SCP_ADDR_TRIM, tv);
         rd(`SCP_ADDR_TRIM, tv);
         chk("trim", {8'h00, tv}, o_rc_osc_trim);
      end
      cyc(1'b1, 1'b0, `SCP_ADDR_CTRL, 8'h05);
      rd(`SCP_ADDR_CTRL, 8'h03);
      cyc(1'b1, 1'b0, `SCP_ADDR_CTRL, 8'h81);
      rd(`SCP_ADDR_CTRL, 8'h03);
      cyc(1'b1, 1'b0, `SCP_ADDR_CTRL, 8'h80);
      rd(`SCP_ADDR_CTRL, 8'h83);
      idle(2);
      cyc(1'b1, 1'b0, `SCP_ADDR_CTRL, 8'h01);
      rd(`SCP_ADDR_CTRL, 8'h03);
      cyc(1'b1, 1'b0, `SCP_ADDR_CTRL, 8'h80);
      idle(2);
      cyc(1'b1, 1'b0, `SCP_ADDR_CTRL, 8'h80);
      idle(1);
      cyc(1'b1, 1'b0, `SCP_ADDR_CTRL, 8'h01);
      rd(`SCP_ADDR_CTRL, 8'h03);
      cyc(1'b1, 1'b0, `SCP_ADDR_CTRL, 8'h80);
      cyc(1'b1, 1'b0, `SCP_ADDR_CTRL, 8'h80);
      idle(2);
      cyc(1'b1, 1'b0, `SCP_ADDR_CTRL, 8'h02);
      cyc(1'b1, 1'b0, `SCP_ADDR_CTRL, 8'h05);
      rd(`SCP_ADDR_CTRL, 8'h02);
      old = 4'h2;
      for (int i = 0; i < 9; i++) begin
         nw = 4'((i + off) % 9);
         el = 0;
         mn = 9'h1FF;
         cyc(1'b1, 1'b0, `SCP_ADDR_CTRL, 8'h80);
         cyc(1'b1, 1'b0, `SCP_ADDR_CTRL, {4'h0, nw});
         // Pulses already in flight from the old rate are skipped until a full new period shows.
         pulse();
         while (m_gap != 9'(1 << nw) && el < 2000) pulse();
         chk("gap", 16'(1 << nw), m_gap);
         chk("min gap", 16'h1, 16'(mn >= ((old < nw) ? (1 << old) : (1 << nw))));
         chk("settle", 16'h1, 16'(el <= (1 << old) + 2 * (1 << nw) + 3));
         chk("skew", 16'h0, 16'(m_skew));
         pulse();
         chk("pin gap", 16'(1 << nw), m_pin_gap);
         rd(`SCP_ADDR_CTRL, {4'h0, nw});
         old = nw;
      end
      i_start_divide_by_eight_fuse <= 1'b0;
      i_chip_reset <= 1'b1;
      cyc(1'b1, 1'b0, `SCP_ADDR_TRIM, 8'h11);
      tg = 0;
      pv = o_clock_out_pin;
      for (int i = 0; i < 300; i++) begin
         idle(1);
         if (o_clock_out_pin !== pv) tg++;
         pv = o_clock_out_pin;
      end
      chk("reset clock", 16'h1, 16'(tg > 4));
      chk("reset pin oe", 16'h1, o_clock_out_pin_oe);
      i_chip_reset <= 1'b0;
      idle(2);
      rd(`SCP_ADDR_CTRL, 8'h00);
      rd(`SCP_ADDR_TRIM, i_factory_trim);
      i_clock_out_fuse <= 1'b0;
      for (int i = 0; i < 8; i++) begin
         i_port_out <= 1'($urandom);
         i_port_oe <= 1'($urandom);
         idle(2);
         chk("pin", {15'h0, i_port_out}, o_clock_out_pin);
         chk("pin oe", {15'h0, i_port_oe}, o_clock_out_pin_oe);
      end
      cyc(1'b1, 1'b0, 2'h3, 8'hA5);
      rd(2'h2, 8'h00);
      rd(`SCP_ADDR_TRIM, i_factory_trim);
      stop_test();
   end
endmodule
`default_nettype wire
